/* File: rtl/sdwc_regs.svh */
`ifndef SDWC_REGS_SVH
`define SDWC_REGS_SVH

// Register word indices and byte offsets, one aligned word each
`define SDWC_IDX_CTRL       5'd0
`define SDWC_IDX_CLKCFG     5'd1
`define SDWC_IDX_DATA0      5'd2
`define SDWC_IDX_DATA_LAST  5'd18
`define SDWC_OFS_CTRL       32'h0000_0000
`define SDWC_OFS_CLKCFG     32'h0000_0004
`define SDWC_OFS_DATA0      32'h0000_0008
`define SDWC_DATA_REGS      17

// Control register fields
`define SDWC_CTRL_EN        7
`define SDWC_CTRL_FAST      6
`define SDWC_CTRL_LOWI      5
`define SDWC_CTRL_CON_HI    3
`define SDWC_CTRL_CON_LO    0
`define SDWC_CTRL_MASK      8'hef
`define SDWC_CTRL_RESET     8'h00

// Clock configuration register fields
`define SDWC_CLK_FCD_HI     6
`define SDWC_CLK_FCD_LO     5
`define SDWC_CLK_DUTY_HI    4
`define SDWC_CLK_DUTY_LO    3
`define SDWC_CLK_DIV_HI     2
`define SDWC_CLK_DIV_LO     0
`define SDWC_CLK_MASK       8'h7f
`define SDWC_CLK_RESET      8'h00

// Oscillator divide ratios for the waveform base clock
`define SDWC_RATIO_128      17'd128
`define SDWC_RATIO_256      17'd256
`define SDWC_RATIO_512      17'd512
`define SDWC_RATIO_1024     17'd1024
`define SDWC_RATIO_16384    17'd16384
`define SDWC_RATIO_32768    17'd32768
`define SDWC_RATIO_65536    17'd65536

// Fast-charge pulse is the base period shifted down by these
`define SDWC_BOOST_SH_32    5
`define SDWC_BOOST_SH_64    6
`define SDWC_BOOST_SH_128   7

// Ladder level codes driven per plane pin
`define SDWC_LVL_VLCD       2'h0
`define SDWC_LVL_VLCD1      2'h1
`define SDWC_LVL_VLCD2      2'h2
`define SDWC_LVL_VLCD3      2'h3

`endif

/* File: rtl/sdwc_pkg.sv */
package sdwc_pkg;

    typedef enum logic [1:0] {
        SDWC_BUS_IDLE = 2'h0,
        SDWC_BUS_READ = 2'h1
    } sdwc_bus_st_t;

    typedef enum logic [1:0] {
        SDWC_DUTY_STATIC  = 2'h0,
        SDWC_DUTY_THIRD   = 2'h1,
        SDWC_DUTY_QUARTER = 2'h2,
        SDWC_DUTY_UNUSED  = 2'h3
    } sdwc_duty_t;

endpackage

/* File: rtl/sdwc_top.sv */
// What this block does
// - The enable bit starts waveform drive on every plane pin the duty uses, 0 stops it, and reset clears it.
// - Low-current 0 picks the 37k ladder, low-current 1 alone picks 146k, both set picks fast charge, reset clears both.
// - A 4-bit read/write contrast code runs from maximum contrast at 0 to minimum at 15.
// - The contrast code picks the lowest bias as a rising fraction of supply, 0.6 to 27.7 percent.
// - In fast charge each base half period starts with a low-resistance pulse of 1/32, 1/64 or 1/128 base period.
// - The fast-charge duration field is read/write, reset to 0, and code 11 is not to be used.
// - Duty 00 is static and 01 is one-third with the shared pin a frontplane, 10 is one-quarter with it a backplane.
// - The duty field is read/write and reset to static, and code 11 is not to be used.
// - The base divider select divides the oscillator by 128, 256, 512 or 1024 for codes 0 to 3, reset giving 128.
// - Codes 4 to 6 divide by 16384, 32768 and 65536, and code 7 is reserved.
// - The divider counts the oscillator output clock itself.
// - Nineteen registers are offered: control, clock configuration and seventeen segment data.
// - A segment data bit of 1 lights its crossing and 0 darkens it, two frontplanes per data register except the last, which drives one.
// - While disabled every plane pin sits at supply and the ladder is disconnected.
// - A frame lasts as many base periods as the multiplex ratio.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sdwc_regs.svh"

module sdwc_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [5:0]  bp_level,
    output logic      [1:0]  shared_plane_level,
    output logic             shared_is_backplane,
    output logic      [63:0] fp_level,
    output logic             ladder_connect,
    output logic             ladder_low_res,
    output logic      [3:0]  contrast_code,
    output logic      [8:0]  bias_permille
);
    import sdwc_pkg::*;

    logic [7:0]   ctrl_r;
    logic [7:0]   clkcfg_r;
    logic [7:0]   seg_data_r [0:`SDWC_DATA_REGS-1];
    sdwc_bus_st_t bus_st_r;
    logic         wr_pend_r;
    logic [4:0]   wr_idx_r;
    logic [4:0]   rd_idx_r;
    logic [7:0]   rd_mux;
    logic         take;
    logic [4:0]   wr_data_idx;
    logic [4:0]   rd_data_idx;

    logic         en;
    logic         boost_mode;
    sdwc_duty_t   duty;
    logic [16:0]  ratio;
    logic [15:0]  half_lim;
    logic [11:0]  boost_width;
    logic [15:0]  div_cnt_r;
    logic         half_tick;
    logic         pol_r;
    logic [1:0]   phase_r;
    logic [1:0]   phase_last;
    logic [11:0]  boost_left_r;
    logic         boost_pulse_r;
    logic [1:0]   bp_lvl_c [0:3];
    logic [1:0]   fp_lvl_c [0:32];

    assign take        = hsel && htrans[1] && hready;
    assign wr_data_idx = wr_idx_r - `SDWC_IDX_DATA0;
    assign rd_data_idx = rd_idx_r - `SDWC_IDX_DATA0;
    assign en          = ctrl_r[`SDWC_CTRL_EN];
    assign boost_mode  = ctrl_r[`SDWC_CTRL_FAST] && ctrl_r[`SDWC_CTRL_LOWI];
    assign duty = sdwc_duty_t'(clkcfg_r[`SDWC_CLK_DUTY_HI:`SDWC_CLK_DUTY_LO]);

    // Bus: writes zero-wait, reads take one wait state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_st_r  <= SDWC_BUS_IDLE;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 5'h0;
            rd_idx_r  <= 5'h0;
        end else begin
            wr_pend_r <= take && hwrite;
            if (take && hwrite) begin
                wr_idx_r <= haddr[6:2];
            end
            unique case (bus_st_r)
                SDWC_BUS_IDLE: begin
                    if (take && !hwrite) begin
                        rd_idx_r  <= haddr[6:2];
                        hreadyout <= 1'b0;
                        bus_st_r  <= SDWC_BUS_READ;
                    end
                end
                SDWC_BUS_READ: begin
                    hrdata    <= {24'h0, rd_mux};
                    hreadyout <= 1'b1;
                    bus_st_r  <= SDWC_BUS_IDLE;
                end
                default: begin
                    hreadyout <= 1'b1;
                    bus_st_r  <= SDWC_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (rd_idx_r == `SDWC_IDX_CTRL) begin
            rd_mux = ctrl_r;
        end else if (rd_idx_r == `SDWC_IDX_CLKCFG) begin
            rd_mux = clkcfg_r;
        end else if (rd_idx_r <= `SDWC_IDX_DATA_LAST) begin
            rd_mux = seg_data_r[rd_data_idx];
        end
    end

    // Control and clock registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r   <= `SDWC_CTRL_RESET;
            clkcfg_r <= `SDWC_CLK_RESET;
        end else if (wr_pend_r) begin
            if (wr_idx_r == `SDWC_IDX_CTRL) begin
                ctrl_r <= hwdata[7:0] & `SDWC_CTRL_MASK;
            end
            if (wr_idx_r == `SDWC_IDX_CLKCFG) begin
                clkcfg_r <= hwdata[7:0] & `SDWC_CLK_MASK;
            end
        end
    end

    // Segment data keeps its contents through reset
    always_ff @(posedge clk) begin
        if (wr_pend_r && wr_idx_r >= `SDWC_IDX_DATA0
                && wr_idx_r <= `SDWC_IDX_DATA_LAST) begin
            seg_data_r[wr_data_idx] <= hwdata[7:0];
        end
    end

    // Divide ratio; reserved code falls back to the slowest rate
    always_comb begin
        unique case (clkcfg_r[`SDWC_CLK_DIV_HI:`SDWC_CLK_DIV_LO])
            3'h0: ratio = `SDWC_RATIO_128;
            3'h1: ratio = `SDWC_RATIO_256;
            3'h2: ratio = `SDWC_RATIO_512;
            3'h3: ratio = `SDWC_RATIO_1024;
            3'h4: ratio = `SDWC_RATIO_16384;
            3'h5: ratio = `SDWC_RATIO_32768;
            3'h6: ratio = `SDWC_RATIO_65536;
            3'h7: ratio = `SDWC_RATIO_65536;
        endcase
        half_lim = 16'((ratio >> 1) - 17'd1);
        unique case (clkcfg_r[`SDWC_CLK_FCD_HI:`SDWC_CLK_FCD_LO])
            2'h0: boost_width = 12'(ratio >> `SDWC_BOOST_SH_32);
            2'h1: boost_width = 12'(ratio >> `SDWC_BOOST_SH_64);
            2'h2: boost_width = 12'(ratio >> `SDWC_BOOST_SH_128);
            2'h3: boost_width = 12'h0;
        endcase
        unique case (duty)
            SDWC_DUTY_THIRD:   phase_last = 2'h2;
            SDWC_DUTY_QUARTER: phase_last = 2'h3;
            default:           phase_last = 2'h0;
        endcase
    end

    // Divider runs straight off the oscillator clock
    assign half_tick = en && (div_cnt_r >= half_lim);

    always_ff @(posedge clk) begin
        if (!rst_b || !en) begin
            div_cnt_r <= 16'h0;
            pol_r     <= 1'b0;
            phase_r   <= 2'h0;
        end else if (half_tick) begin
            div_cnt_r <= 16'h0;
            pol_r     <= ~pol_r;
            if (pol_r) begin
                phase_r <= (phase_r >= phase_last) ? 2'h0
                                                   : phase_r + 2'h1;
            end
        end else begin
            div_cnt_r <= div_cnt_r + 16'h1;
        end
    end

    // Fast-charge pulse at the start of each half period
    always_ff @(posedge clk) begin
        if (!rst_b || !en) begin
            boost_left_r  <= 12'h0;
            boost_pulse_r <= 1'b0;
        end else if (half_tick) begin
            boost_left_r  <= boost_width - 12'(boost_width != 12'h0);
            boost_pulse_r <= boost_width != 12'h0;
        end else begin
            boost_left_r  <= boost_left_r - 12'(boost_left_r != 12'h0);
            boost_pulse_r <= boost_left_r != 12'h0;
        end
    end

    // Plane levels; unused backplanes rest at supply
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_bp
            always_comb begin
                if (!en || 2'(k) > phase_last) begin
                    bp_lvl_c[k] = `SDWC_LVL_VLCD;
                end else if (duty == SDWC_DUTY_STATIC
                        || phase_r == 2'(k)) begin
                    bp_lvl_c[k] = pol_r ? `SDWC_LVL_VLCD3
                                        : `SDWC_LVL_VLCD;
                end else begin
                    bp_lvl_c[k] = pol_r ? `SDWC_LVL_VLCD1
                                        : `SDWC_LVL_VLCD2;
                end
            end
        end
        for (k = 0; k < 33; k++) begin : g_fp
            logic lit;
            assign lit = seg_data_r[k / 2][(k % 2) * 4 + phase_r];
            always_comb begin
                if (!en) begin
                    fp_lvl_c[k] = `SDWC_LVL_VLCD;
                end else if (lit) begin
                    fp_lvl_c[k] = pol_r ? `SDWC_LVL_VLCD
                                        : `SDWC_LVL_VLCD3;
                end else if (duty == SDWC_DUTY_STATIC) begin
                    fp_lvl_c[k] = pol_r ? `SDWC_LVL_VLCD3
                                        : `SDWC_LVL_VLCD;
                end else begin
                    fp_lvl_c[k] = pol_r ? `SDWC_LVL_VLCD2
                                        : `SDWC_LVL_VLCD1;
                end
            end
            if (k > 0) begin : g_out
                always_ff @(posedge clk) begin
                    if (!rst_b) begin
                        fp_level[2*k-1:2*k-2] <= `SDWC_LVL_VLCD;
                    end else begin
                        fp_level[2*k-1:2*k-2] <= fp_lvl_c[k];
                    end
                end
            end
        end
    endgenerate

    function automatic logic [8:0] bias_of(input logic [3:0] code);
        unique case (code)
            4'h0: bias_of = 9'd6;
            4'h1: bias_of = 9'd29;
            4'h2: bias_of = 9'd52;
            4'h3: bias_of = 9'd74;
            4'h4: bias_of = 9'd96;
            4'h5: bias_of = 9'd116;
            4'h6: bias_of = 9'd135;
            4'h7: bias_of = 9'd153;
            4'h8: bias_of = 9'd172;
            4'h9: bias_of = 9'd188;
            4'ha: bias_of = 9'd205;
            4'hb: bias_of = 9'd220;
            4'hc: bias_of = 9'd236;
            4'hd: bias_of = 9'd250;
            4'he: bias_of = 9'd264;
            4'hf: bias_of = 9'd277;
        endcase
    endfunction

    // Backplanes, shared pin and ladder controls
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bp_level            <= 6'h0;
            shared_plane_level  <= `SDWC_LVL_VLCD;
            shared_is_backplane <= 1'b0;
            ladder_connect      <= 1'b0;
            ladder_low_res      <= 1'b1;
            contrast_code       <= 4'h0;
            bias_permille       <= 9'd6;
        end else begin
            bp_level <= {bp_lvl_c[2], bp_lvl_c[1], bp_lvl_c[0]};
            shared_is_backplane <= duty == SDWC_DUTY_QUARTER;
            shared_plane_level  <= (duty == SDWC_DUTY_QUARTER)
                                   ? bp_lvl_c[3] : fp_lvl_c[0];
            ladder_connect <= en;
            ladder_low_res <= !ctrl_r[`SDWC_CTRL_LOWI]
                              || (boost_mode && boost_pulse_r);
            contrast_code  <= ctrl_r[`SDWC_CTRL_CON_HI:`SDWC_CTRL_CON_LO];
            bias_permille  <= bias_of(
                ctrl_r[`SDWC_CTRL_CON_HI:`SDWC_CTRL_CON_LO]);
        end
    end

    // Checks
    logic [15:0] gap_cnt_r;
    logic        gap_seen_r;
    always_ff @(posedge clk) begin
        if (!rst_b || !en || wr_pend_r) begin
            gap_cnt_r  <= 16'h0;
            gap_seen_r <= 1'b0;
        end else if (half_tick) begin
            gap_cnt_r  <= 16'h0;
            gap_seen_r <= 1'b1;
        end else begin
            gap_cnt_r  <= gap_cnt_r + 16'h1;
        end
    end

    sequence s_boost_start;
        half_tick && boost_mode && !wr_pend_r
            && clkcfg_r[`SDWC_CLK_FCD_HI:`SDWC_CLK_FCD_LO] == 2'h0
            && clkcfg_r[`SDWC_CLK_DIV_HI:`SDWC_CLK_DIV_LO] == 3'h0;
    endsequence
    sequence s_boost_pulse4;
        ladder_low_res [*4] ##1 !ladder_low_res;
    endsequence

    a_disable_blank: assert property (@(posedge clk) disable iff (!rst_b)
        !en |=> bp_level == 6'h0 && fp_level == 64'h0 && !ladder_connect)
        else $error("Disabled display not blank");
    a_enable_ladder: assert property (@(posedge clk) disable iff (!rst_b)
        en |=> ladder_connect)
        else $error("Ladder not connected while enabled");
    a_ladder_37k: assert property (@(posedge clk) disable iff (!rst_b)
        !ctrl_r[`SDWC_CTRL_LOWI] |=> ladder_low_res)
        else $error("Low-current clear but ladder not low resistance");
    a_ladder_146k: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_r[`SDWC_CTRL_LOWI] && !ctrl_r[`SDWC_CTRL_FAST] |=> !ladder_low_res)
        else $error("Low-current set but ladder low resistance");
    a_boost_width: assert property (@(posedge clk) disable iff (!rst_b)
        s_boost_start |=> ##1 s_boost_pulse4)
        else $error("Fast-charge pulse not four cycles at divide 128");
    a_bias_ends: assert property (@(posedge clk) disable iff (!rst_b)
        (contrast_code == 4'h0 |-> bias_permille == 9'd6)
        and (contrast_code == 4'hf |-> bias_permille == 9'd277))
        else $error("Bias fraction wrong at contrast extreme");
    a_bias_rises: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && contrast_code > $past(contrast_code)
            |-> bias_permille > $past(bias_permille))
        else $error("Bias fraction not monotonic");
    a_shared_pin: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 shared_is_backplane == ($past(duty) == SDWC_DUTY_QUARTER))
        else $error("Shared pin role does not follow duty");
    a_reset_clear: assert property (@(posedge clk)
        !rst_b |=> ctrl_r == 8'h00 && clkcfg_r == 8'h00)
        else $error("Control fields not cleared by reset");
    a_div_period: assert property (@(posedge clk) disable iff (!rst_b)
        half_tick && gap_seen_r |-> 17'({gap_cnt_r, 1'b0}) + 17'd2 == ratio)
        else $error("Base half period does not match divide ratio");
    a_frame_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        half_tick && pol_r && duty == SDWC_DUTY_THIRD && phase_r == 2'h2
            && !wr_pend_r |=> phase_r == 2'h0)
        else $error("One-third duty frame not three periods");
    a_static_phase: assert property (@(posedge clk) disable iff (!rst_b)
        en && duty == SDWC_DUTY_STATIC
            |=> (fp_level[1:0] != bp_level[1:0]) == $past(seg_data_r[0][4]))
        else $error("Static frontplane phase does not follow data");

endmodule // sdwc_top
`default_nettype wire

/* File: tb/sdwc_panel.sv */
`timescale 1ns/1ns
`default_nettype none

module sdwc_panel (
    input  wire logic        clk,
    input  wire logic [5:0]  bp_level,
    input  wire logic [63:0] fp_level,
    output logic      [31:0] full_cnt
);
    // Counts cycles of full drive across the first segment cell
    initial full_cnt = 32'h0;
    always @(posedge clk) begin
        if ((bp_level[1:0] == 2'h0 && fp_level[1:0] == 2'h3) ||
            (bp_level[1:0] == 2'h3 && fp_level[1:0] == 2'h0)) begin
            full_cnt <= full_cnt + 32'h1;
        end
    end
endmodule // sdwc_panel

`default_nettype wire

/* File: tb/sdwc_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sdwc_regs.svh"

module sdwc_top_test;
    logic        clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, shared_plane_level;
    logic [2:0]  hsize;
    logic [5:0]  bp_level;
    logic [63:0] fp_level;
    logic        shared_is_backplane, ladder_connect, ladder_low_res;
    logic [3:0]  contrast_code;
    logic [8:0]  bias_permille;
    logic [31:0] full_cnt;
    logic [7:0]  mdl [0:31];
    int          miscompares, checked, cycles, w, g, n, ratio, base;
    int          bias_tab [0:15] = '{6, 29, 52, 74, 96, 116, 135, 153,
                                     172, 188, 205, 220, 236, 250, 264, 277};

    sdwc_top i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .bp_level(bp_level),
        .shared_plane_level(shared_plane_level),
        .shared_is_backplane(shared_is_backplane), .fp_level(fp_level),
        .ladder_connect(ladder_connect), .ladder_low_res(ladder_low_res),
        .contrast_code(contrast_code), .bias_permille(bias_permille));
    sdwc_panel i_panel (.clk(clk), .bp_level(bp_level),
        .fp_level(fp_level), .full_cnt(full_cnt));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single word transfer; hready is the slave's own hreadyout
    task automatic ahb(input logic wr, input int idx, input logic [31:0] wd);
        int t;
        t = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= 32'(idx * 4);
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 100);
        rd = hrdata;
        chk("hresp", 64'(hresp), 64'h0);
    endtask

    task automatic reg_wr(input int idx, input logic [31:0] v);
        ahb(1'b1, idx, v);
        if (idx == 0) mdl[idx] = v[7:0] & `SDWC_CTRL_MASK;
        else if (idx == 1) mdl[idx] = v[7:0] & `SDWC_CLK_MASK;
        else if (idx <= 18) mdl[idx] = v[7:0];
    endtask

    task automatic reg_chk(input int idx);
        ahb(1'b0, idx, 32'h0);
        chk("register", 64'(rd), 64'(idx <= 18 ? mdl[idx] : 8'h00));
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    // Length of the next fast-charge pulse and rise-to-rise spacing
    task automatic pulse();
        int t;
        t = 0;
        w = 0;
        while (ladder_low_res === 1'b1 && ++t < 20000) @(posedge clk);
        while (ladder_low_res !== 1'b1 && ++t < 20000) @(posedge clk);
        while (ladder_low_res === 1'b1 && w < 20000) begin
            w++;
            @(posedge clk);
        end
        g = w;
        while (ladder_low_res !== 1'b1 && g < 20000) begin
            g++;
            @(posedge clk);
        end
    endtask

    initial begin
        miscompares = 0;
        checked = 0;
        cycles = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mdl[0] = `SDWC_CTRL_RESET;
        mdl[1] = `SDWC_CLK_RESET;
        void'($urandom(34738));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        reg_chk(0);
        reg_chk(1);
        chk("ladder_connect", 64'(ladder_connect), 64'h0);
        chk("bias", 64'(bias_permille), 64'd6);
        chk("shared", 64'(shared_is_backplane), 64'h0);
        // Random fill of every index, legal clock codes only
        for (int i = 0; i < 32; i++) begin
            rd = $urandom;
            if (i == 0) rd[`SDWC_CTRL_EN] = 1'b0; // Data not yet written
            if (i == 1) rd[6:0] = {2'($urandom % 3), 2'($urandom % 3),
                                   3'($urandom % 7)};
            reg_wr(i, rd);
        end
        for (int i = 0; i < 32; i++) reg_chk(i);
        // Contrast codes and ladder selection while disabled
        for (int c = 0; c < 16; c++) begin
            reg_wr(0, {25'h0, 1'(c % 4 == 2), 1'(c % 2), 1'b0, 4'(c)});
            settle();
            chk("contrast", 64'(contrast_code), 64'(c));
            chk("bias", 64'(bias_permille), 64'(bias_tab[c]));
            chk("low_res", 64'(ladder_low_res), 64'(c % 2 == 0));
        end
        // Fast-charge pulse width and base half period for divider codes 0 to 4
        for (int d = 0; d < 5; d++) begin
            ratio = (d < 4) ? (128 << d) : 16384;
            reg_wr(1, {25'h0, 2'(d % 3), 2'h0, 3'(d)});
            reg_wr(0, 32'h0000_00e0);
            pulse();
            pulse();
            chk("boost_width", 64'(w), 64'(ratio >> (5 + d % 3)));
            chk("half_period", 64'(g), 64'(ratio / 2));
        end
        // Frame length and shared pin role per duty
        reg_wr(0, 32'h0000_0080);
        for (int duty = 0; duty < 3; duty++) begin
            reg_wr(1, {27'h0, 2'(duty), 3'h0});
            base = (duty == 0) ? 1 : duty + 2;
            settle();
            chk("shared", 64'(shared_is_backplane), 64'(duty == 2));
            chk("ladder_on", 64'(ladder_connect), 64'h1);
            n = 0;
            repeat (256 * base) begin
                @(posedge clk);
                if (bp_level[1:0] === 2'h0 || bp_level[1:0] === 2'h3) n++;
            end
            chk("backplane_zero_select", 64'(n), 64'd256);
        end
        // Static segment lit, then dark, seen by the panel
        reg_wr(1, 32'h0);
        for (int lit = 1; lit >= 0; lit--) begin
            reg_wr(2, lit ? 32'h0000_0010 : 32'h0000_0000);
            settle();
            n = full_cnt;
            repeat (256) @(posedge clk);
            chk("segment", 64'(full_cnt - n), 64'(lit * 256));
        end
        reg_wr(2, 32'h0000_0010);
        reg_wr(0, 32'h0);
        settle();
        chk("ladder_connect", 64'(ladder_connect), 64'h0);
        chk("bp_level", 64'(bp_level), 64'h0);
        chk("fp_level", fp_level, 64'h0);
        chk("shared_lvl", 64'(shared_plane_level), 64'h0);
        complete_run();
    end
endmodule // sdwc_top_test

`default_nettype wire
